// ===== common/tgcpe_params.svh
// constants for the time gain ramp engine: offsets, fields, counts
`ifndef TGCPE_PARAMS_SVH
`define TGCPE_PARAMS_SVH
`define TGCPE_ADDR_GP0 8'h00
`define TGCPE_BIT_RDEN 1
`define TGCPE_BIT_BANK 2
`define TGCPE_TBL_LO 8'h01
`define TGCPE_TBL_HI 8'h94
`define TGCPE_TBL_DEPTH 148
`define TGCPE_ADDR_FIRST 8'h95
`define TGCPE_ADDR_LAST 8'h96
`define TGCPE_ADDR_IGAIN 8'h97
`define TGCPE_ADDR_DWELL 8'h98
`define TGCPE_ADDR_MODE 8'h99
`define TGCPE_ADDR_WHOLE 8'h9A
`define TGCPE_ADDR_RATE 8'h9B
`define TGCPE_BIT_FINE_EN 7
`define TGCPE_BIT_SOFT 5
`define TGCPE_BIT_LIN 4
`define TGCPE_BIT_FIXED 3
`define TGCPE_DB_MAX 6'h24
`define TGCPE_GAIN_MAX 9'h120
`define TGCPE_HOLD_MULT 16'h0021
`define TGCPE_CLK_NS 50
`define TGCPE_SAMP_CLKS 2
`define TGCPE_SAMP_NS (`TGCPE_CLK_NS * `TGCPE_SAMP_CLKS)
`define TGCPE_FRAME_LAST 5'h17
`define TGCPE_ADDR_LASTBIT 5'h07
`define TGCPE_FRAME_BITS 5'h18
`define TGCPE_RST_ZERO 8'h00
`endif

// ===== common/tgcpe_pkg.sv
// types shared by the time gain ramp engine
package tgcpe_pkg;
  typedef enum logic [1:0] {
    TGCPE_IDLE,
    TGCPE_STEP,
    TGCPE_HOLD,
    TGCPE_RETURN
  } tgcpe_state_t;

  // one step entry: direction and duration code
  typedef struct packed {
    logic dec;
    logic [7:0] dur;
  } tgcpe_entry_t;

  // gain in eighth-dB units above -5 dB; whole*8+eighth
  typedef struct packed {
    logic [5:0] whole;
    logic [2:0] eighth;
  } tgcpe_gain_t;
endpackage

// ===== rtl/tgcpe_engine.sv
// time gain ramp engine with serial register port and step table
`timescale 1ns/1ps
`include "tgcpe_params.svh"

module tgcpe_engine (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ser_clk,
  input wire logic ser_en_n,
  input wire logic ser_din,
  input wire logic trig_pin,
  output logic ser_dout,
  output tgcpe_pkg::tgcpe_gain_t gain_out,
  output logic gain_strobe,
  output logic curve_active
);
  // pin synchronisers; stage 0 feeds only stage 1
  logic [2:0] sclk_s, trig_s;
  logic [1:0] sen_s, sdi_s;
  logic sclk_rise, sen_act, trig_rise;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sclk_s <= 3'h0;
      sen_s <= 2'h3;
      sdi_s <= 2'h0;
      trig_s <= 3'h0;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], ser_clk};
      sen_s <= {sen_s[0], ser_en_n};
      sdi_s <= {sdi_s[0], ser_din};
      trig_s <= {trig_s[1:0], trig_pin};
    end
  end
  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign sen_act = ~sen_s[1];
  assign trig_rise = trig_s[1] & ~trig_s[2];
  // sample tick: every second input clock
  logic ph_r, tick;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ph_r <= 1'b0;
    else
      ph_r <= ~ph_r;
  end
  assign tick = ph_r;
  // serial frame: 8 address bits then 16 data bits, msb first
  logic [4:0] bit_cnt_r;
  logic [22:0] sh_r;
  logic [23:0] frame;
  logic wr_evt, rd_load;
  logic [7:0] wr_addr, rd_addr;
  logic [15:0] wr_data, rd_word, rd_sh_r;
  assign frame = {sh_r, sdi_s[1]};
  assign wr_addr = frame[23:16];
  assign wr_data = frame[15:0];
  assign rd_addr = frame[7:0];
  always_ff @(posedge clk_sys)
  begin
    if (rst || !sen_act)
    begin
      bit_cnt_r <= 5'h00;
      sh_r <= 23'h000000;
    end
    else if (sclk_rise && bit_cnt_r != `TGCPE_FRAME_BITS)
    begin
      sh_r <= frame[22:0];
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end
  // registers
  logic bank_r, rden_r, fine_en_r, soft_r, lin_r, fixed_r;
  logic [7:0] first_r, last_r, dwell_r, rate_r;
  logic [5:0] ig_r, whole_r;
  logic [2:0] fine_r;
  logic [8:0] tbl [1:`TGCPE_TBL_DEPTH];
  // readout mode leaves only register zero writable, so it can be left
  assign wr_evt = sclk_rise && sen_act && bit_cnt_r == `TGCPE_FRAME_LAST;
  assign rd_load = sclk_rise && sen_act && rden_r
    && bit_cnt_r == `TGCPE_ADDR_LASTBIT;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bank_r <= 1'b0;
      rden_r <= 1'b0;
      first_r <= `TGCPE_RST_ZERO;
      last_r <= `TGCPE_RST_ZERO;
      ig_r <= 6'h00;
      fine_en_r <= 1'b0;
      dwell_r <= `TGCPE_RST_ZERO;
      soft_r <= 1'b0;
      lin_r <= 1'b0;
      fixed_r <= 1'b0;
      fine_r <= 3'h0;
      whole_r <= 6'h00;
      rate_r <= `TGCPE_RST_ZERO;
    end
    else if (wr_evt)
    begin
      if (wr_addr == `TGCPE_ADDR_GP0)
      begin
        bank_r <= wr_data[`TGCPE_BIT_BANK];
        rden_r <= wr_data[`TGCPE_BIT_RDEN];
      end
      else if (bank_r && !rden_r)
      begin
        unique case (wr_addr)
          `TGCPE_ADDR_FIRST: first_r <= wr_data[7:0];
          `TGCPE_ADDR_LAST: last_r <= wr_data[7:0];
          `TGCPE_ADDR_IGAIN:
          begin
            ig_r <= wr_data[5:0];
            fine_en_r <= wr_data[`TGCPE_BIT_FINE_EN];
          end
          `TGCPE_ADDR_DWELL: dwell_r <= wr_data[7:0];
          `TGCPE_ADDR_MODE:
          begin
            soft_r <= wr_data[`TGCPE_BIT_SOFT];
            lin_r <= wr_data[`TGCPE_BIT_LIN];
            fixed_r <= wr_data[`TGCPE_BIT_FIXED];
            fine_r <= wr_data[2:0];
          end
          `TGCPE_ADDR_WHOLE: whole_r <= wr_data[5:0];
          `TGCPE_ADDR_RATE: rate_r <= wr_data[7:0];
          default: ;
        endcase
      end
    end
  end
  // table storage has no reset; software loads it before use
  always_ff @(posedge clk_sys)
  begin
    if (wr_evt && bank_r && !rden_r && wr_addr >= `TGCPE_TBL_LO
        && wr_addr <= `TGCPE_TBL_HI)
      tbl[wr_addr] <= wr_data[8:0];
  end
  always_comb
  begin
    rd_word = 16'h0000;
    if (rd_addr == `TGCPE_ADDR_GP0)
      rd_word = {13'h0000, bank_r, rden_r, 1'b0};
    else if (bank_r)
    begin
      if (rd_addr >= `TGCPE_TBL_LO && rd_addr <= `TGCPE_TBL_HI)
        rd_word = {7'h00, tbl[rd_addr]};
      else
      begin
        unique case (rd_addr)
          `TGCPE_ADDR_FIRST: rd_word = {8'h00, first_r};
          `TGCPE_ADDR_LAST: rd_word = {8'h00, last_r};
          `TGCPE_ADDR_IGAIN: rd_word = {8'h00, fine_en_r, 1'b0, ig_r};
          `TGCPE_ADDR_DWELL: rd_word = {8'h00, dwell_r};
          `TGCPE_ADDR_MODE:
            rd_word = {10'h000, soft_r, lin_r, fixed_r, fine_r};
          `TGCPE_ADDR_WHOLE: rd_word = {10'h000, whole_r};
          `TGCPE_ADDR_RATE: rd_word = {8'h00, rate_r};
          default: rd_word = 16'h0000;
        endcase
      end
    end
  end
  // readback: bit changes a few clocks after each sclk rise
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rd_sh_r <= 16'h0000;
      ser_dout <= 1'b0;
    end
    else if (sclk_rise && sen_act && rden_r)
    begin
      rd_sh_r <= {(rd_load ? rd_word[14:0] : rd_sh_r[14:0]), 1'b0};
      ser_dout <= rd_load ? rd_word[15] : rd_sh_r[15];
    end
  end
  // trigger capture; a rise during a clear still counts
  logic pend_r, start_evt;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pend_r <= 1'b0;
    else if (trig_rise)
      pend_r <= 1'b1;
    else if (tick)
      pend_r <= 1'b0;
  end
  assign start_evt = tick && !fixed_r && (pend_r || trig_rise);
  // step engine
  tgcpe_pkg::tgcpe_state_t state_r;
  tgcpe_pkg::tgcpe_entry_t entry;
  logic [7:0] idx_r, sub_r, n_raw, n_eff;
  logic [2:0] eighth_r;
  logic [15:0] hold_r, hold_load;
  logic [3:0] move;
  logic [9:0] g_up, g_dn;
  logic [8:0] g_cur, start_code, fixed_code;
  logic [5:0] ig_sat, whole_sat;
  logic dir_dn, sub_done, lim_hit;
  assign g_cur = gain_out;
  assign ig_sat = (ig_r > `TGCPE_DB_MAX) ? `TGCPE_DB_MAX : ig_r;
  assign start_code = {ig_sat, 3'h0};
  assign whole_sat = (whole_r > `TGCPE_DB_MAX) ? `TGCPE_DB_MAX
    : whole_r;
  assign fixed_code = {whole_sat, fine_r};
  assign hold_load = {8'h00, dwell_r} * `TGCPE_HOLD_MULT;
  // out-of-range index reads as zero; software keeps pointers legal
  assign entry = (idx_r >= `TGCPE_TBL_LO && idx_r <= `TGCPE_TBL_HI)
    ? tbl[idx_r] : 9'h000;
  assign n_raw = lin_r ? rate_r : entry.dur;
  assign n_eff = (n_raw == 8'h00) ? 8'h01 : n_raw;
  assign dir_dn = lin_r ? 1'b0 : entry.dec;
  assign sub_done = (sub_r == n_eff - 8'h01);
  assign move = fine_en_r ? 4'h1 : ((eighth_r == 3'h7) ? 4'h8 : 4'h0);
  assign g_up = {1'b0, g_cur} + {6'h00, move};
  assign g_dn = {1'b0, g_cur} - {6'h00, move};
  assign lim_hit = dir_dn ? g_dn[9] : (g_up > {1'b0, `TGCPE_GAIN_MAX});
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_r <= tgcpe_pkg::TGCPE_IDLE;
      gain_out <= 9'h000;
      idx_r <= `TGCPE_RST_ZERO;
      sub_r <= `TGCPE_RST_ZERO;
      eighth_r <= 3'h0;
      hold_r <= 16'h0000;
    end
    else if (tick)
    begin
      if (fixed_r)
      begin
        state_r <= tgcpe_pkg::TGCPE_IDLE;
        gain_out <= fixed_code;
      end
      else if (start_evt)
      begin
        state_r <= tgcpe_pkg::TGCPE_STEP;
        gain_out <= start_code;
        idx_r <= first_r;
        sub_r <= `TGCPE_RST_ZERO;
        eighth_r <= 3'h0;
      end
      else
      begin
        unique case (state_r)
          tgcpe_pkg::TGCPE_IDLE:
          begin
            if (soft_r)
            begin
              state_r <= tgcpe_pkg::TGCPE_STEP;
              gain_out <= start_code;
              idx_r <= first_r;
              sub_r <= `TGCPE_RST_ZERO;
              eighth_r <= 3'h0;
            end
          end
          tgcpe_pkg::TGCPE_STEP:
          begin
            if (!sub_done)
              sub_r <= sub_r + 8'h01;
            else
            begin
              sub_r <= `TGCPE_RST_ZERO;
              eighth_r <= eighth_r + 3'h1;
              if (lim_hit)
              begin
                gain_out <= dir_dn ? 9'h000 : `TGCPE_GAIN_MAX;
                state_r <= tgcpe_pkg::TGCPE_HOLD;
                hold_r <= hold_load;
              end
              else
              begin
                // coarse mode moves once per 8 sub-periods
                gain_out <= dir_dn ? g_dn[8:0] : g_up[8:0];
                if (eighth_r == 3'h7)
                begin
                  if (idx_r == last_r)
                  begin
                    state_r <= tgcpe_pkg::TGCPE_HOLD;
                    hold_r <= hold_load;
                  end
                  else
                    idx_r <= idx_r + 8'h01;
                end
              end
            end
          end
          tgcpe_pkg::TGCPE_HOLD:
          begin
            if (hold_r == 16'h0000)
              state_r <= tgcpe_pkg::TGCPE_RETURN;
            else
              hold_r <= hold_r - 16'h0001;
          end
          tgcpe_pkg::TGCPE_RETURN:
          begin
            if (g_cur > start_code)
              gain_out <= (g_cur - start_code > 9'h008)
                ? g_cur - 9'h008 : start_code;
            else if (g_cur < start_code)
              gain_out <= (start_code - g_cur > 9'h008)
                ? g_cur + 9'h008 : start_code;
            else if (soft_r)
            begin
              state_r <= tgcpe_pkg::TGCPE_STEP;
              idx_r <= first_r;
              sub_r <= `TGCPE_RST_ZERO;
              eighth_r <= 3'h0;
            end
            else
              state_r <= tgcpe_pkg::TGCPE_IDLE;
          end
        endcase
      end
    end
  end
  // status outputs, registered
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      gain_strobe <= 1'b0;
      curve_active <= 1'b0;
    end
    else
    begin
      gain_strobe <= tick;
      curve_active <= (state_r != tgcpe_pkg::TGCPE_IDLE);
    end
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_tick_alternates: assert property (tick |=> !tick ##1 tick)
    else $error("sample tick not every second clock");
  a_gain_on_tick: assert property ($changed(gain_out) |-> $past(tick))
    else $error("gain changed off the sample tick");
  // fixed mode may reach 31.875 dB, so only the running curve is bounded
  a_gain_in_range: assert property (state_r != tgcpe_pkg::TGCPE_IDLE
    |-> gain_out <= `TGCPE_GAIN_MAX)
    else $error("gain out of range");
  a_bank_after_rst: assert property ($past(rst) |-> !bank_r)
    else $error("bank select not zero after reset");
  a_reg0_reach: assert property (wr_evt && wr_addr == `TGCPE_ADDR_GP0
    |=> bank_r == $past(wr_data[`TGCPE_BIT_BANK]))
    else $error("register zero write lost");
  a_fixed_value: assert property (tick && fixed_r |=>
    gain_out == $past(fixed_code) && state_r == tgcpe_pkg::TGCPE_IDLE)
    else $error("fixed gain not applied");
  a_trig_start: assert property (start_evt && !fixed_r |=>
    state_r == tgcpe_pkg::TGCPE_STEP && gain_out == $past(start_code)
    && idx_r == $past(first_r))
    else $error("trigger did not start curve");
  a_hold_count: assert property (tick && !fixed_r && !start_evt
    && state_r == tgcpe_pkg::TGCPE_HOLD && hold_r != 16'h0000
    |=> hold_r == $past(hold_r) - 16'h0001)
    else $error("hold counter did not count");
  a_return_step: assert property (tick && !fixed_r && !start_evt
    && state_r == tgcpe_pkg::TGCPE_RETURN
    && g_cur > start_code + 9'h008
    |=> g_cur == $past(g_cur) - 9'h008)
    else $error("return step not one dB");
  a_soft_restart: assert property (tick && !fixed_r && !start_evt
    && state_r == tgcpe_pkg::TGCPE_RETURN && g_cur == start_code
    |=> state_r == (soft_r ? tgcpe_pkg::TGCPE_STEP
    : tgcpe_pkg::TGCPE_IDLE))
    else $error("wrong state after return");
endmodule

// ===== test/tgcpe_ctl_model.sv
// serial register master and trigger source facing the gain engine
`timescale 1ns/1ps

module tgcpe_ctl_model (
  input wire logic clk_sys,
  input wire logic ser_dout,
  output logic ser_clk,
  output logic ser_en_n,
  output logic ser_din,
  output logic trig_pin
);
  initial
  begin
    ser_clk = 1'b0;
    ser_en_n = 1'b1;
    ser_din = 1'b0;
    trig_pin = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // address byte then data word, msb first; q collects the readback
  task automatic xfer(input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    logic [23:0] f;
    f = {a, d};
    q = 16'h0000;
    @(negedge clk_sys);
    ser_en_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      ser_din = f[i];
      wait_n(4);
      if (i < 16)
        q[i] = ser_dout;
      ser_clk = 1'b1;
      wait_n(4);
      ser_clk = 1'b0;
    end
    wait_n(4);
    ser_en_n = 1'b1;
    // no pull on the data line: a stale level must not look valid
    ser_din = ~ser_din;
    wait_n(4);
  endtask

  // held for one full sample period so that one tick sees it
  task automatic pulse();
    @(negedge clk_sys);
    trig_pin = 1'b1;
    wait_n(2);
    trig_pin = 1'b0;
  endtask
endmodule

// ===== test/tgcpe_engine_tb.sv
// self-checking bench for the time gain ramp engine
`timescale 1ns/1ps

module tgcpe_engine_tb;
  logic clk_sys, rst, ser_clk, ser_en_n, ser_din, trig_pin, ser_dout;
  logic gain_strobe, curve_active;
  tgcpe_pkg::tgcpe_gain_t gain_out, gain_prev;
  logic [15:0] q;
  int n_errors = 0;
  int cmp_count = 0;
  int n;

  tgcpe_engine dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .ser_clk(ser_clk),
    .ser_en_n(ser_en_n),
    .ser_din(ser_din),
    .trig_pin(trig_pin),
    .ser_dout(ser_dout),
    .gain_out(gain_out),
    .gain_strobe(gain_strobe),
    .curve_active(curve_active)
  );

  tgcpe_ctl_model ctl (
    .clk_sys(clk_sys),
    .ser_dout(ser_dout),
    .ser_clk(ser_clk),
    .ser_en_n(ser_en_n),
    .ser_din(ser_din),
    .trig_pin(trig_pin)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    ctl.xfer(a, d, q);
  endtask

  // readout frame; register zero gets its own value back as data
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    ctl.xfer(a, (a == 8'h00) ? 16'h0006 : 16'h0000, q);
    chk(q, exp);
  endtask

  // n counts sample ticks until gain_out reaches v
  task automatic wait_gain(input logic [8:0] v, input int bound);
    n = 0;
    for (int i = 0; i < bound; i++)
    begin
      @(negedge clk_sys);
      if (gain_strobe === 1'b1)
        n++;
      chk(gain_out > 9'h120, 16'h0000);
      if (gain_out === v)
        return;
    end
    chk(gain_out, v);
    close_out();
  endtask

  task automatic wait_idle();
    for (n = 0; n < 400 && curve_active !== 1'b0; n++)
      @(negedge clk_sys);
    chk(curve_active, 16'h0000);
    if (curve_active !== 1'b0)
      close_out();
  endtask

  // entry 2 up with N=2, entry 3 up with code 0, dwell 1
  task automatic run_curve(input logic [7:0] ig, input logic [8:0] b);
    wr(8'h97, {8'h00, ig});
    ctl.pulse();
    wait_gain(b, 20);
    if (ig[7])
    begin
      wait_gain(b + 9'h001, 100);
      chk(n, 16'h0002);
      wait_gain(b + 9'h008, 100);
      chk(n, 16'h000E);
    end
    else
    begin
      wait_gain(b + 9'h008, 100);
      chk(n, 16'h0010);
    end
    wait_gain(b + 9'h010, 100);
    chk(n, 16'h0008);
    wait_gain(b + 9'h008, 200);
    chk(n >= 33 && n <= 36, 16'h0001);
    wait_gain(b, 20);
    chk(n, 16'h0001);
    repeat (100) @(negedge clk_sys);
    chk(gain_out, b);
    wait_idle();
  endtask

  // gain may only move on the clock that follows a sample tick
  always @(negedge clk_sys)
  begin
    if (rst === 1'b0 && gain_out !== gain_prev)
      chk(gain_strobe, 16'h0001);
    gain_prev <= gain_out;
  end

  initial
  begin
    rst = 1'b1;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    wr(8'h00, 16'h0004);
    wr(8'h05, 16'h0000);
    wr(8'h00, 16'h0000);
    wr(8'h05, 16'h01FF);
    wr(8'h00, 16'h0006);
    rd(8'h00, 16'h0006);
    rd(8'h05, 16'h0000);
    for (int a = 8'h95; a <= 8'h9C; a++)
      rd(a[7:0], 16'h0000);
    wr(8'h00, 16'h0004);
    wr(8'h01, 16'h01FF);
    wr(8'h94, 16'h01AB);
    wr(8'h95, 16'h0094);
    wr(8'h00, 16'h0006);
    rd(8'h01, 16'h01FF);
    rd(8'h94, 16'h01AB);
    rd(8'h95, 16'h0094);
    wr(8'h00, 16'h0004);
    $display("test registers done");
    wr(8'h9A, 16'h003F);
    wr(8'h99, 16'h000D);
    ctl.pulse();
    repeat (4) @(negedge clk_sys);
    chk(gain_out, 16'h0125);
    wr(8'h9A, 16'h0010);
    repeat (4) @(negedge clk_sys);
    chk(gain_out, 16'h0085);
    wr(8'h99, 16'h0000);
    $display("test fixed gain done");
    wr(8'h02, 16'h0002);
    wr(8'h03, 16'h0000);
    wr(8'h95, 16'h0002);
    wr(8'h96, 16'h0003);
    wr(8'h98, 16'h0001);
    run_curve(8'h86, 9'h030);
    run_curve(8'h08, 9'h040);
    $display("test table curve done");
    wr(8'h97, 16'h00A3);
    ctl.pulse();
    wait_gain(9'h118, 20);
    wait_gain(9'h120, 100);
    wait_gain(9'h118, 200);
    chk(n >= 33 && n <= 37, 16'h0001);
    wait_idle();
    $display("test gain limit done");
    wr(8'h97, 16'h0086);
    wr(8'h99, 16'h0020);
    wait_gain(9'h040, 200);
    wait_gain(9'h030, 200);
    wait_gain(9'h040, 200);
    wr(8'h99, 16'h0000);
    wait_idle();
    $display("test register trigger done");
    wr(8'h9B, 16'h0003);
    wr(8'h96, 16'h0002);
    wr(8'h99, 16'h0010);
    wr(8'h97, 16'h0087);
    ctl.pulse();
    wait_gain(9'h038, 20);
    wait_gain(9'h039, 100);
    chk(n, 16'h0003);
    $display("test linear ramp done");
    close_out();
  end
endmodule
